// ===== lcc_pkg.sv
// Operation
// - 0x50 writes, 0x51 reads gain byte
// - bit 7 bypasses input attenuator
// - bits 6,5 add tx gain, rx loss
// - bits 4:0 set signed-offset scaling gain
// - 10000 gives loopback, zero gives cutoff
// - 0x52/0x53 write/read line I/O data
// - data always latched, driven only when output
// - alternate bit acts only with E1 mux
// - line_io_7/6 are output-only, no direction
// - 0x54/0x55 direction; bit 7 reserved
// - bit 6 reads channel active, write 0
// - bit 5 global clock unsynced flag
// - bits 4:0 pin directions, 1 output
// - 0x60/0x61 write/read operating functions
// - filter bit 0 default, 1 programmed set
// - only enabled channels take commands
// - select default store or programmed memory
package lcc_pkg;
	localparam int NUM_CH = 4;
	localparam int NUM_DIR_PINS = 5;
	localparam int NUM_FILT = 6;

	// ----------------------------------------------------------------
	// link commands (bit 0 is read/write)
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_GAIN = 8'h50;
	localparam logic [7:0] CMD_IODATA = 8'h52;
	localparam logic [7:0] CMD_IODIR = 8'h54;
	localparam logic [7:0] CMD_OPFUNC = 8'h60;
	localparam int CMD_RD_BIT = 0;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int GAIN_ATTEN_OFF_BIT = 7;
	localparam int GAIN_TX_BOOST_BIT = 6;
	localparam int GAIN_RX_LOSS_BIT = 5;
	localparam logic [4:0] SCALE_LOOPBACK = 5'h10;
	localparam logic [4:0] SCALE_CUTOFF = 5'h00;
	localparam int IO_HI_LSB = 6;
	localparam int IO_ALT_BIT = 5;
	localparam int DIR_ACTIVE_BIT = 6;
	localparam int DIR_UNSYNC_BIT = 5;
	localparam int OPF_LINEAR_BIT = 7;
	localparam int OPF_MULAW_BIT = 6;
	localparam logic [7:0] RST_GAIN = 8'h00;
	localparam logic [7:0] RST_IODATA = 8'h00;
	localparam logic [4:0] RST_IODIR = 5'h00;
	localparam logic [7:0] RST_OPFUNC = 8'h00;

	// ----------------------------------------------------------------
	// host controller APB map
	// ----------------------------------------------------------------
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_INT_STAT = 8'h08;
	localparam logic [7:0] APB_INT_MASK = 8'h0C;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_REFUSED_BIT = 1;
	localparam logic [1:0] RST_INT_MASK = 2'h0;
endpackage

// ===== lcc_link_if.sv
`timescale 1ns/1ps
interface lcc_link_if;
	logic       reqValid;
	logic [7:0] reqCmd;
	logic [7:0] reqData;
	logic       ackValid;
	logic [7:0] ackData;

	modport host (
		output reqValid,
		output reqCmd,
		output reqData,
		input  ackValid,
		input  ackData
	);
	modport dev (
		input  reqValid,
		input  reqCmd,
		input  reqData,
		output ackValid,
		output ackData
	);
endinterface

// ===== lcc_channel_regs.sv
`timescale 1ns/1ps
module lcc_channel_regs (
	input  logic                  ref_clk,
	input  logic                  sys_rst,
	lcc_link_if.dev               link,
	input  logic [3:0]            chanEnable,
	input  logic [3:0]            channelActive,
	input  logic                  clockUnsynced,
	input  logic                  e1MuxEnable,
	input  logic [3:0][4:0]       lineIoIn,
	output logic [3:0][4:0]       lineIoOut,
	output logic [3:0][4:0]       lineIoOe,
	output logic [3:0][1:0]       lineIoHiOut,
	output logic [3:0]            lineIo1AltOut,
	output logic [3:0]            inputAttenOff,
	output logic [3:0]            txAnalogBoost,
	output logic [3:0]            rxAnalogLoss,
	output logic [3:0][4:0]       impedanceScaleCoeff,
	output logic [3:0]            fullDigitalLoopback,
	output logic [3:0]            scaleCutoff,
	output logic [3:0]            linearCodeSel,
	output logic [3:0]            companding,
	output logic [3:0][5:0]       filterUseProgrammed
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0][7:0] gain;
		logic [3:0][7:0] ioData;
		logic [3:0][4:0] ioDir;
		logic [3:0][7:0] opFunc;
		logic [3:0][4:0] pinSync1;
		logic [3:0][4:0] pinSync2;
		logic [3:0]      loopback;
		logic [3:0]      cutoff;
		logic [3:0]      altOut;
		logic            ack;
		logic [7:0]      ackData;
	} lcc_dev_s;

	lcc_dev_s cur;
	lcc_dev_s next_cur;

	logic       take;
	logic       isRead;
	logic [7:0] base;
	logic [7:0] rdByte;
	logic       rdHit;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		take = link.reqValid && !cur.ack;
		isRead = link.reqCmd[lcc_pkg::CMD_RD_BIT];
		base = {link.reqCmd[7:1], 1'b0};
		rdByte = 8'h00;
		rdHit = 1'b0;

		// ------------------------------------------------------------
		// pin synchronisers: pins come from outside the clock domain
		// ------------------------------------------------------------
		next_cur.pinSync1 = lineIoIn;
		next_cur.pinSync2 = cur.pinSync1;

		// ------------------------------------------------------------
		// link handshake
		// ------------------------------------------------------------
		// one request, one acknowledge; request held until ack seen
		next_cur.ack = take;
		next_cur.ackData = 8'h00;

		// ------------------------------------------------------------
		// channel writes and reads
		// ------------------------------------------------------------
		// each channel holds its own copy
		for (int c = lcc_pkg::NUM_CH - 1; c >= 0; c--) begin
			if (take && chanEnable[c] && !isRead) begin
				case (base)
					lcc_pkg::CMD_GAIN: begin
						next_cur.gain[c] = link.reqData;
					end
					lcc_pkg::CMD_IODATA: begin
						next_cur.ioData[c] = link.reqData;
					end
					lcc_pkg::CMD_IODIR: begin
						next_cur.ioDir[c] = link.reqData[4:0];
					end
					lcc_pkg::CMD_OPFUNC: begin
						next_cur.opFunc[c] = link.reqData;
					end
					default: begin
					end
				endcase
			end
			// lowest enabled channel answers a read, loop runs downward
			if (take && chanEnable[c] && isRead) begin
				rdHit = 1'b1;
				case (base)
					lcc_pkg::CMD_GAIN: begin
						rdByte = cur.gain[c];
					end
					lcc_pkg::CMD_IODATA: begin
						// input-mode pins read the pin, others the latch
						rdByte = cur.ioData[c];
						for (int b = 0; b < lcc_pkg::NUM_DIR_PINS; b++) begin
							if (!cur.ioDir[c][b]) begin
								rdByte[b] = cur.pinSync2[c][b];
							end
						end
					end
					lcc_pkg::CMD_IODIR: begin
						rdByte = {1'b0,
							channelActive[c],
							clockUnsynced,
							cur.ioDir[c]};
					end
					lcc_pkg::CMD_OPFUNC: begin
						rdByte = cur.opFunc[c];
					end
					default: begin
						rdByte = 8'h00;
					end
				endcase
			end
		end

		// ------------------------------------------------------------
		// read answer
		// ------------------------------------------------------------
		// status still readable with no channel enabled
		if (take && isRead && !rdHit && base == lcc_pkg::CMD_IODIR) begin
			rdByte = {2'b00, clockUnsynced, 5'h00};
		end
		if (take && isRead) begin
			next_cur.ackData = rdByte;
		end

		// ------------------------------------------------------------
		// decoded modes
		// ------------------------------------------------------------
		// decoded scaling modes, registered with the field
		for (int c = 0; c < lcc_pkg::NUM_CH; c++) begin
			next_cur.loopback[c] =
				next_cur.gain[c][4:0] == lcc_pkg::SCALE_LOOPBACK;
			next_cur.cutoff[c] =
				next_cur.gain[c][4:0] == lcc_pkg::SCALE_CUTOFF;
			// alternate bit ignored unless E1 mux on
			next_cur.altOut[c] = e1MuxEnable &&
				next_cur.ioData[c][lcc_pkg::IO_ALT_BIT];
		end

		// ------------------------------------------------------------
		// synchronous reset, overrides everything above
		// ------------------------------------------------------------
		if (sys_rst) begin
			for (int c = 0; c < lcc_pkg::NUM_CH; c++) begin
				next_cur.gain[c] = lcc_pkg::RST_GAIN;
				next_cur.ioData[c] = lcc_pkg::RST_IODATA;
				next_cur.ioDir[c] = lcc_pkg::RST_IODIR;
				next_cur.opFunc[c] = lcc_pkg::RST_OPFUNC;
				// decoded modes follow the reset field value
				next_cur.loopback[c] =
					lcc_pkg::RST_GAIN[4:0] == lcc_pkg::SCALE_LOOPBACK;
				next_cur.cutoff[c] =
					lcc_pkg::RST_GAIN[4:0] == lcc_pkg::SCALE_CUTOFF;
			end
			next_cur.pinSync1 = '0;
			next_cur.pinSync2 = '0;
			next_cur.altOut = '0;
			next_cur.ack = 1'b0;
			next_cur.ackData = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		cur <= next_cur;
	end

	// ----------------------------------------------------------------
	// outputs, all straight from state bits
	// ----------------------------------------------------------------
	assign link.ackValid = cur.ack;
	assign link.ackData = cur.ackData;
	assign lineIo1AltOut = cur.altOut;
	assign fullDigitalLoopback = cur.loopback;
	assign scaleCutoff = cur.cutoff;

	for (genvar c = 0; c < lcc_pkg::NUM_CH; c++) begin : g_ch
		// latch always kept; enable only where direction is output
		assign lineIoOut[c] = cur.ioData[c][4:0];
		assign lineIoOe[c] = cur.ioDir[c];
		// no direction control on the upper two pins
		assign lineIoHiOut[c] = cur.ioData[c][7:lcc_pkg::IO_HI_LSB];
		assign inputAttenOff[c] =
			cur.gain[c][lcc_pkg::GAIN_ATTEN_OFF_BIT];
		assign txAnalogBoost[c] =
			cur.gain[c][lcc_pkg::GAIN_TX_BOOST_BIT];
		assign rxAnalogLoss[c] =
			cur.gain[c][lcc_pkg::GAIN_RX_LOSS_BIT];
		// gain = 0.0625 * attenuator gain * (field - 16)
		assign impedanceScaleCoeff[c] = cur.gain[c][4:0];
		assign linearCodeSel[c] =
			cur.opFunc[c][lcc_pkg::OPF_LINEAR_BIT];
		assign companding[c] =
			cur.opFunc[c][lcc_pkg::OPF_MULAW_BIT];
		// per stage: 0 fixed store, 1 programmed memory
		assign filterUseProgrammed[c] = cur.opFunc[c][5:0];
	end
endmodule

// ===== lcc_host_ctrl.sv
`timescale 1ns/1ps
module lcc_host_ctrl (
	input  logic        ref_clk,
	input  logic        sys_rst,
	lcc_link_if.host    link,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	output logic        irq
);
	typedef struct packed {
		logic        reqValid;
		logic [7:0]  reqCmd;
		logic [7:0]  reqData;
		logic [7:0]  lastRead;
		logic [1:0]  intStat;
		logic [1:0]  intMask;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic        irq;
	} lcc_host_s;

	lcc_host_s cur;
	lcc_host_s next_cur;

	logic       setup;
	logic       done;
	logic [1:0] events;
	logic       mapped;

	always_comb begin
		next_cur = cur;
		setup = psel && !penable;
		done = psel && penable && cur.ready;
		events = 2'b00;
		mapped = paddr == lcc_pkg::APB_CMD ||
			paddr == lcc_pkg::APB_STATUS ||
			paddr == lcc_pkg::APB_INT_STAT ||
			paddr == lcc_pkg::APB_INT_MASK;

		// ------------------------------------------------------------
		// link: hold request until the device acknowledges
		// ------------------------------------------------------------
		if (cur.reqValid && link.ackValid) begin
			next_cur.reqValid = 1'b0;
			next_cur.lastRead = link.ackData;
			events[lcc_pkg::INT_DONE_BIT] = 1'b1;
		end

		// ------------------------------------------------------------
		// APB: no wait state, read data prepared in setup
		// ------------------------------------------------------------
		next_cur.ready = setup;
		if (setup) begin
			next_cur.err = !mapped;
			case (paddr)
				lcc_pkg::APB_STATUS: begin
					next_cur.rdata = {16'h0000, cur.lastRead, 7'h00,
						cur.reqValid};
				end
				lcc_pkg::APB_INT_STAT: begin
					next_cur.rdata = {30'h0, cur.intStat};
				end
				lcc_pkg::APB_INT_MASK: begin
					next_cur.rdata = {30'h0, cur.intMask};
				end
				default: begin
					next_cur.rdata = 32'h0000_0000;
				end
			endcase
		end else if (done) begin
			next_cur.err = 1'b0;
		end
		if (done && pwrite && paddr == lcc_pkg::APB_CMD) begin
			if (cur.reqValid) begin
				events[lcc_pkg::INT_REFUSED_BIT] = 1'b1;
			end else begin
				// host passes reserved/status bits on as written, unmasked
				next_cur.reqValid = 1'b1;
				next_cur.reqCmd = pwdata[7:0];
				next_cur.reqData = pwdata[15:8];
			end
		end
		if (done && pwrite && paddr == lcc_pkg::APB_INT_MASK) begin
			next_cur.intMask = pwdata[1:0];
		end
		// read clears, a new event in the same cycle wins
		if (done && !pwrite && paddr == lcc_pkg::APB_INT_STAT) begin
			next_cur.intStat = events;
		end else begin
			next_cur.intStat = cur.intStat | events;
		end
		next_cur.irq = |(next_cur.intStat & next_cur.intMask);

		if (sys_rst) begin
			next_cur = '0;
			next_cur.intMask = lcc_pkg::RST_INT_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		cur <= next_cur;
	end

	assign link.reqValid = cur.reqValid;
	assign link.reqCmd = cur.reqCmd;
	assign link.reqData = cur.reqData;
	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.err;
	assign irq = cur.irq;
endmodule

// ===== lcc_chk.sv
`timescale 1ns/1ps
module lcc_chk (
	input logic       ref_clk,
	input logic       sys_rst,
	input logic       reqValid,
	input logic [7:0] reqCmd,
	input logic [7:0] reqData,
	input logic       ackValid,
	input logic [7:0] ackData
);
	logic [7:0] prevCmd;

	always_ff @(posedge ref_clk) prevCmd <= reqCmd;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// link handshake
	// ----------------------------------------------------------------
	ack_pulse_a: assert property (ackValid |=> !ackValid)
		else $error("ack longer than one cycle");
	ack_prompt_a: assert property (reqValid && !ackValid |=> ackValid)
		else $error("request not answered next cycle");
	ack_cause_a: assert property (ackValid |-> $past(reqValid))
		else $error("ack without request");
	req_hold_a: assert property (reqValid && !ackValid |=>
		reqValid && $stable(reqCmd) && $stable(reqData))
		else $error("request changed before ack");
	req_drop_a: assert property (ackValid |=> !reqValid)
		else $error("request kept after ack");
	wr_zero_a: assert property (ackValid && !prevCmd[0] |->
		ackData == 8'h00)
		else $error("write answered with data");
	odd_cmd_a: assert property (ackValid && !(prevCmd[7:1] inside
		{7'h28, 7'h29, 7'h2A, 7'h30}) |-> ackData == 8'h00)
		else $error("unknown command answered with data");
	rst_quiet_a: assert property (@(posedge ref_clk) disable iff (1'b0)
		sys_rst |=> !ackValid && !reqValid)
		else $error("link busy after reset");
endmodule

// ===== line_codec_channel_config_regs_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module line_codec_channel_config_regs_bench;
	logic            ref_clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic [3:0]      chanEnable = 4'hF;
	logic [3:0]      channelActive = 4'h0;
	logic            clockUnsynced = 1'b0;
	logic            e1MuxEnable = 1'b0;
	logic [3:0][4:0] lineIoIn = '0;
	logic [3:0][4:0] lineIoOut, lineIoOe, impedanceScaleCoeff;
	logic [3:0][1:0] lineIoHiOut;
	logic [3:0]      lineIo1AltOut, inputAttenOff, txAnalogBoost;
	logic [3:0]      rxAnalogLoss, fullDigitalLoopback, scaleCutoff;
	logic [3:0]      linearCodeSel, companding;
	logic [3:0][5:0] filterUseProgrammed;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0;
	logic [31:0]     prdata, v;
	logic            pready, pslverr, irq, i0, verr;
	logic [7:0]      m [4][4] = '{default: 8'h00};
	logic [7:0]      op, d, r, e, codes [9];
	logic [3:0]      en, act;
	logic [19:0]     pins;
	logic            uns, e1;
	int              n_fail = 0;
	int              checks_done = 0;
	int              seed = 32'h5953A80E;
	int              c, j, i, lo;

	lcc_link_if lcc_link_if_i ();
	lcc_channel_regs lcc_channel_regs_i (.ref_clk, .sys_rst,
		.link(lcc_link_if_i.dev), .chanEnable, .channelActive,
		.clockUnsynced, .e1MuxEnable, .lineIoIn, .lineIoOut, .lineIoOe,
		.lineIoHiOut, .lineIo1AltOut, .inputAttenOff, .txAnalogBoost,
		.rxAnalogLoss, .impedanceScaleCoeff, .fullDigitalLoopback,
		.scaleCutoff, .linearCodeSel, .companding, .filterUseProgrammed);
	lcc_host_ctrl lcc_host_ctrl_i (.ref_clk, .sys_rst,
		.link(lcc_link_if_i.host), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq);
	lcc_chk lcc_chk_i (.ref_clk, .sys_rst,
		.reqValid(lcc_link_if_i.reqValid), .reqCmd(lcc_link_if_i.reqCmd),
		.reqData(lcc_link_if_i.reqData), .ackValid(lcc_link_if_i.ackValid),
		.ackData(lcc_link_if_i.ackData));

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	// b2b keeps psel up so the next setup follows at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		input logic b2b);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		v = prdata;
		verr = pslverr;
		penable <= 1'b0;
		if (!b2b) begin
			psel <= 1'b0;
			@(posedge ref_clk);
		end
	endtask

	task cmd(input logic [7:0] cc, input logic [7:0] dd);
		apb(1'b1, lcc_pkg::APB_CMD, {16'h0, dd, cc}, 1'b0);
		v = 32'h1;
		while (v[0] !== 1'b0)
			apb(1'b0, lcc_pkg::APB_STATUS, 32'h0, 1'b0);
		r = v[15:8];
	endtask

	task check_outs;
		for (int c = 0; c < 4; c++) begin
			`CHK(lineIoOut[c], m[c][1][4:0])
			`CHK(lineIoOe[c], m[c][2][4:0])
			`CHK(lineIoHiOut[c], m[c][1][7:6])
			`CHK(lineIo1AltOut[c], m[c][1][5] & e1)
			`CHK({inputAttenOff[c], txAnalogBoost[c], rxAnalogLoss[c],
				impedanceScaleCoeff[c]}, m[c][0])
			`CHK(fullDigitalLoopback[c], m[c][0][4:0] == 5'h10)
			`CHK(scaleCutoff[c], m[c][0][4:0] == 5'h00)
			`CHK({linearCodeSel[c], companding[c], filterUseProgrammed[c]},
				m[c][3])
		end
	endtask

	task stop_test;
		$display("checks %0d, failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial forever #5 ref_clk = ~ref_clk;

	initial begin
		#100us;
		n_fail++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		codes = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h60, 8'h61,
			8'h70};
		e1 = 1'b0;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		check_outs();
		for (i = 0; i < 80; i++) begin
			en = (i < 9) ? 4'hF : $random(seed);
			if (i == 9) en = 4'h0;
			act = $random(seed);
			uns = $random(seed);
			e1 = $random(seed);
			pins = $random(seed);
			chanEnable <= en;
			channelActive <= act;
			clockUnsynced <= uns;
			e1MuxEnable <= e1;
			lineIoIn <= pins;
			repeat (4) @(posedge ref_clk);
			op = (i < 9) ? codes[i] : codes[$unsigned($random(seed)) % 9];
			if (i == 9) op = 8'h55; // clock flag with no channel on
			d = (i == 0) ? 8'h10 : $random(seed);
			if (op == 8'h54) d[7:6] = 2'b00;
			cmd(op, d);
			case (op[7:1])
				7'h28: j = 0;
				7'h29: j = 1;
				7'h2A: j = 2;
				7'h30: j = 3;
				default: j = -1;
			endcase
			for (c = 3; c >= 0; c--)
				if (!op[0] && j >= 0 && en[c])
					m[c][j] = (j == 2) ? {3'b000, d[4:0]} : d;
			lo = 0;
			for (c = 3; c >= 0; c--)
				if (en[c]) lo = c;
			c = lo;
			case (j)
				0: e = m[c][0];
				1: e = {m[c][1][7:5], (m[c][1][4:0] & m[c][2][4:0]) |
					(pins[c*5 +: 5] & ~m[c][2][4:0])};
				2: e = {1'b0, act[c], uns, m[c][2][4:0]};
				3: e = m[c][3];
				default: e = 8'h00;
			endcase
			if (en == 4'h0) e = (j == 2) ? {2'b00, uns, 5'h00} : 8'h00;
			if (!op[0]) e = 8'h00;
			`CHK(r, e)
			check_outs();
		end
		apb(1'b0, lcc_pkg::APB_INT_STAT, 32'h0, 1'b0);
		apb(1'b1, lcc_pkg::APB_CMD, 32'h0050, 1'b1);
		apb(1'b1, lcc_pkg::APB_CMD, 32'h0050, 1'b0);
		repeat (6) @(posedge ref_clk);
		i0 = irq;
		apb(1'b1, lcc_pkg::APB_INT_MASK, 32'h3, 1'b0);
		`CHK(i0, 1'b0)
		`CHK(irq, 1'b1)
		apb(1'b0, lcc_pkg::APB_INT_STAT, 32'h0, 1'b0);
		`CHK(v[1:0], 2'b11)
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h40, 32'h0, 1'b0);
		`CHK({verr, v}, 33'h100000000)
		stop_test();
	end
endmodule
